// [design/fpc_map.svh]
// register offsets, field positions and reset values of the pwm core
`ifndef FPC_MAP_SVH
`define FPC_MAP_SVH

// register byte offsets
`define FPC_ADR_CLKSEL 8'h00
`define FPC_ADR_OEN 8'h04
`define FPC_ADR_PHL 8'h08
`define FPC_ADR_PHH 8'h0C
`define FPC_ADR_PRL 8'h10
`define FPC_ADR_PRH 8'h14
`define FPC_ADR_FRAC 8'h18
`define FPC_ADR_CTRL 8'h1C
`define FPC_ADR_STAT 8'h20

// clock select fields
`define FPC_SRC_LSB 0
`define FPC_PRE_LSB 4
`define FPC_CLKSEL_MASK 8'h33
`define FPC_SRC_SYS 2'h0
`define FPC_SRC_PLL 2'h1
`define FPC_SRC_PIN 2'h2

// output enable masks
`define FPC_OEN_MASK_FULL 8'h3F
`define FPC_OEN_MASK_AB 8'h03

// fractional adjust width
`define FPC_FRAC_W 4

// control fields
`define FPC_CTRL_MODE_LSB 0
`define FPC_CTRL_FRAC_BIT 2
`define FPC_CTRL_MASK 8'h07

// reset values
`define FPC_RST_BYTE 8'h00
`define FPC_RST_WORD 32'h0000_0000

`endif

// [design/fpc_pkg.sv]
// types shared by the pwm core
package fpc_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_ACK = 2'h2
  } fpc_bus_state_t;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_NORMAL = 2'h1,
    MODE_FIXED_PAIR = 2'h2,
    MODE_FIXED_SAME = 2'h3
  } fpc_mode_t;

endpackage : fpc_pkg

// [design/fpc_clk_sel.sv]
// controller clock source selection and prescaler
`timescale 1ns/1ps
`include "fpc_map.svh"
module fpc_clk_sel (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // selection
  input wire logic [1:0] srcSel,
  input wire logic [1:0] preSel,
  // clock sources from outside
  input wire logic pllClk,
  input wire logic extClkPin,
  // controller tick
  output logic ctrlTick
);

  logic pllSync1_reg, pllSync2_reg, pllLast_reg;
  logic extSync1_reg, extSync2_reg, extLast_reg;
  logic rawTick;
  logic [2:0] preCnt_reg;

  function automatic logic [2:0] preMask(input logic [1:0] sel);
    preMask = 3'((4'h1 << sel) - 4'h1);
  endfunction : preMask

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pllSync1_reg <= 1'b0;
      pllSync2_reg <= 1'b0;
      pllLast_reg <= 1'b0;
      extSync1_reg <= 1'b0;
      extSync2_reg <= 1'b0;
      extLast_reg <= 1'b0;
    end else begin
      pllSync1_reg <= pllClk;
      pllSync2_reg <= pllSync1_reg;
      pllLast_reg <= pllSync2_reg;
      extSync1_reg <= extClkPin;
      extSync2_reg <= extSync1_reg;
      extLast_reg <= extSync2_reg;
    end
  end

  always_comb begin
    case (srcSel)
      `FPC_SRC_SYS: rawTick = 1'b1;
      `FPC_SRC_PLL: rawTick = pllSync2_reg & ~pllLast_reg;
      `FPC_SRC_PIN: rawTick = extSync2_reg & ~extLast_reg;
      default: rawTick = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      preCnt_reg <= 3'h0;
      ctrlTick <= 1'b0;
    end else begin
      if (rawTick) begin
        preCnt_reg <= preCnt_reg + 3'h1;
      end
      ctrlTick <= rawTick && ((preCnt_reg & preMask(preSel)) == preMask(preSel));
    end
  end

  a_reserved_src: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (srcSel == 2'h3) [*2] |=> !ctrlTick) else $error("tick from reserved source");
  a_div_spacing: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (preSel == 2'h3) [*8] ##0 ctrlTick |-> $past(ctrlTick) == 1'b0)
    else $error("prescaler gave ticks too close");

endmodule : fpc_clk_sel

// [design/fpc_frac_acc.sv]
// fractional period accumulator
`timescale 1ns/1ps
`include "fpc_map.svh"
module fpc_frac_acc (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // control
  input wire logic enable,
  input wire logic advance,
  input wire logic [`FPC_FRAC_W-1:0] fracValue,
  // result
  output logic extend,
  output logic [`FPC_FRAC_W-1:0] accum
);

  logic [`FPC_FRAC_W:0] sum;

  assign sum = {1'b0, accum} + {1'b0, fracValue};

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      accum <= '0;
      extend <= 1'b0;
    end else if (!enable) begin
      accum <= '0;
      extend <= 1'b0;
    end else if (advance) begin
      accum <= sum[`FPC_FRAC_W-1:0];
      extend <= sum[`FPC_FRAC_W];
    end
  end

  a_carry_extends: assert property (@(posedge sys_clk) disable iff (!reset_n)
    enable && advance |=> extend == $past(sum[`FPC_FRAC_W]) && accum == $past(accum + fracValue))
    else $error("carry not turned into extension");

endmodule : fpc_frac_acc

// [design/fpc_top.sv]
// pwm core with fractional period adjust and wishbone register file
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "fpc_map.svh"
//
// Notes on behaviour
// - carry of accumulator lengthens next event
// - fractional adjust only in fixed-duty modes
// - fixed-duty period is two period events
// - one fraction step adds step over sixteen
// - source: system, pll, pin; 11 reserved
// - enable bit routes pwm, else port data
// - second unit keeps only A and B enables
// - unimplemented bits read as zero
// - phase count split low and high byte
// - registers clear to zero on reset
//
module fpc_top #(
  parameter bit SECOND_UNIT = 1'b0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // clock sources
  input wire logic pllClk,
  input wire logic extClkPin,
  // port side of the pins
  input wire logic [5:0] portData,
  // pins and events
  output logic [5:0] pinOut,
  output logic periodEvent
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  fpc_pkg::fpc_bus_state_t busState_reg;
  fpc_pkg::fpc_mode_t mode;
  logic [7:0] clkSel_reg;
  logic [7:0] oen_reg;
  logic [7:0] phaseLow_reg;
  logic [7:0] phaseHigh_reg;
  logic [7:0] periodLow_reg;
  logic [7:0] periodHigh_reg;
  logic [`FPC_FRAC_W-1:0] frac_reg;
  logic [7:0] ctrl_reg;
  logic [15:0] phaseCount;
  logic [15:0] periodValue;
  logic [16:0] eventCnt_reg;
  logic [16:0] limit;
  logic ctrlTick;
  logic extend;
  logic [`FPC_FRAC_W-1:0] accum;
  logic fixedMode;
  logic running;
  logic eventEnd;
  logic pwmLevel_reg;
  logic [5:0] pwmVec;
  logic wrStrobe;
  logic rdStrobe;
  logic [7:0] rdByte;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [7:0] oenMask(input logic second);
    oenMask = second ? `FPC_OEN_MASK_AB : `FPC_OEN_MASK_FULL;
  endfunction : oenMask

  function automatic logic [5:0] spread(input logic lvl, input logic invert);
    logic other;
    other = invert ? ~lvl : lvl;
    spread = {other, lvl, other, lvl, other, lvl};
  endfunction : spread

  ////////////////////////////////////////////////////////////////////////////
  // field decode

  assign mode = fpc_pkg::fpc_mode_t'(ctrl_reg[`FPC_CTRL_MODE_LSB +: 2]);
  assign fixedMode = (mode == fpc_pkg::MODE_FIXED_PAIR) || (mode == fpc_pkg::MODE_FIXED_SAME);
  assign running = (mode != fpc_pkg::MODE_OFF);
  assign phaseCount = {phaseHigh_reg, phaseLow_reg};
  assign periodValue = {periodHigh_reg, periodLow_reg};
  assign limit = {1'b0, periodValue} + {16'h0000, extend};
  assign eventEnd = running && ctrlTick && (eventCnt_reg >= limit);

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake

  assign wrStrobe = (busState_reg == fpc_pkg::BUS_ACK) && wb_cyc_i && wb_stb_i && wb_we_i
                    && wb_sel_i[0];
  assign rdStrobe = (busState_reg == fpc_pkg::BUS_IDLE) && wb_cyc_i && wb_stb_i && !wb_we_i;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      busState_reg <= fpc_pkg::BUS_IDLE;
      wb_ack_o <= 1'b0;
    end else begin
      case (busState_reg)
        fpc_pkg::BUS_IDLE: begin
          if (wb_cyc_i && wb_stb_i) begin
            busState_reg <= fpc_pkg::BUS_ACK;
            wb_ack_o <= 1'b1;
          end
        end
        fpc_pkg::BUS_ACK: begin
          busState_reg <= fpc_pkg::BUS_IDLE;
          wb_ack_o <= 1'b0;
        end
        default: begin
          busState_reg <= fpc_pkg::BUS_IDLE;
          wb_ack_o <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      clkSel_reg <= `FPC_RST_BYTE;
      oen_reg <= `FPC_RST_BYTE;
      phaseLow_reg <= `FPC_RST_BYTE;
      phaseHigh_reg <= `FPC_RST_BYTE;
      periodLow_reg <= `FPC_RST_BYTE;
      periodHigh_reg <= `FPC_RST_BYTE;
      frac_reg <= '0;
      ctrl_reg <= `FPC_RST_BYTE;
    end else if (wrStrobe) begin
      case (wb_adr_i)
        `FPC_ADR_CLKSEL: clkSel_reg <= wb_dat_i[7:0] & `FPC_CLKSEL_MASK;
        `FPC_ADR_OEN: oen_reg <= wb_dat_i[7:0] & oenMask(SECOND_UNIT);
        `FPC_ADR_PHL: phaseLow_reg <= wb_dat_i[7:0];
        `FPC_ADR_PHH: phaseHigh_reg <= wb_dat_i[7:0];
        `FPC_ADR_PRL: periodLow_reg <= wb_dat_i[7:0];
        `FPC_ADR_PRH: periodHigh_reg <= wb_dat_i[7:0];
        `FPC_ADR_FRAC: frac_reg <= wb_dat_i[`FPC_FRAC_W-1:0];
        `FPC_ADR_CTRL: ctrl_reg <= wb_dat_i[7:0] & `FPC_CTRL_MASK;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads

  always_comb begin
    case (wb_adr_i)
      `FPC_ADR_CLKSEL: rdByte = clkSel_reg;
      `FPC_ADR_OEN: rdByte = oen_reg;
      `FPC_ADR_PHL: rdByte = phaseLow_reg;
      `FPC_ADR_PHH: rdByte = phaseHigh_reg;
      `FPC_ADR_PRL: rdByte = periodLow_reg;
      `FPC_ADR_PRH: rdByte = periodHigh_reg;
      `FPC_ADR_FRAC: rdByte = {{(8 - `FPC_FRAC_W){1'b0}}, frac_reg};
      `FPC_ADR_CTRL: rdByte = ctrl_reg;
      `FPC_ADR_STAT: rdByte = {accum, 1'b0, extend, pwmLevel_reg, running};
      default: rdByte = `FPC_RST_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wb_dat_o <= `FPC_RST_WORD;
    end else if (rdStrobe) begin
      wb_dat_o <= {24'h00_0000, rdByte};
    end else begin
      wb_dat_o <= `FPC_RST_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // controller clock

  fpc_clk_sel u_clk_sel (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .srcSel(clkSel_reg[`FPC_SRC_LSB +: 2]),
    .preSel(clkSel_reg[`FPC_PRE_LSB +: 2]),
    .pllClk(pllClk),
    .extClkPin(extClkPin),
    .ctrlTick(ctrlTick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // fractional accumulator

  fpc_frac_acc u_frac_acc (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .enable(fixedMode && ctrl_reg[`FPC_CTRL_FRAC_BIT]),
    .advance(eventEnd),
    .fracValue(frac_reg),
    .extend(extend),
    .accum(accum)
  );

  ////////////////////////////////////////////////////////////////////////////
  // period event counter

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      eventCnt_reg <= 17'h0_0000;
    end else if (!running) begin
      eventCnt_reg <= 17'h0_0000;
    end else if (eventEnd) begin
      eventCnt_reg <= 17'h0_0000;
    end else if (ctrlTick) begin
      eventCnt_reg <= eventCnt_reg + 17'h0_0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      periodEvent <= 1'b0;
    end else begin
      periodEvent <= eventEnd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm level

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pwmLevel_reg <= 1'b0;
    end else begin
      case (mode)
        fpc_pkg::MODE_NORMAL: begin
          if (ctrlTick) begin
            pwmLevel_reg <= (eventCnt_reg >= {1'b0, phaseCount});
          end
        end
        fpc_pkg::MODE_FIXED_PAIR, fpc_pkg::MODE_FIXED_SAME: begin
          if (eventEnd) begin
            pwmLevel_reg <= ~pwmLevel_reg;
          end
        end
        default: pwmLevel_reg <= 1'b0;
      endcase
    end
  end

  assign pwmVec = spread(pwmLevel_reg, mode != fpc_pkg::MODE_FIXED_SAME);

  ////////////////////////////////////////////////////////////////////////////
  // pin routing

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pinOut <= 6'h00;
    end else begin
      pinOut <= (oen_reg[5:0] & pwmVec) | (~oen_reg[5:0] & portData);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_ack_one_cycle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");

  a_event_base_len: assert property (@(posedge sys_clk) disable iff (!reset_n)
    running && ctrlTick && eventCnt_reg == {1'b0, periodValue} + {16'h0000, extend}
    ##1 running |-> periodEvent && eventCnt_reg == 17'h0_0000)
    else $error("period event not at period plus one");

  a_no_early_event: assert property (@(posedge sys_clk) disable iff (!reset_n)
    running && eventCnt_reg < limit |=> !periodEvent)
    else $error("period event before limit");

  a_no_frac_normal: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !fixedMode [*2] |-> !extend && accum == '0)
    else $error("fraction active outside fixed duty");

  a_fixed_toggle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    fixedMode && eventEnd ##1 fixedMode |-> pwmLevel_reg != $past(pwmLevel_reg))
    else $error("fixed duty level did not toggle");

  a_pin_port: assert property (@(posedge sys_clk) disable iff (!reset_n)
    oen_reg[5:0] == 6'h00 |=> pinOut == $past(portData))
    else $error("disabled pin not under port control");

  a_pin_pwm: assert property (@(posedge sys_clk) disable iff (!reset_n)
    oen_reg[0] |=> pinOut[0] == $past(pwmLevel_reg))
    else $error("enabled pin not carrying pwm");

  a_second_oen: assert property (@(posedge sys_clk) disable iff (!reset_n)
    SECOND_UNIT |-> oen_reg[5:2] == 4'h0)
    else $error("absent enable bits set");

  a_clk_reserved: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rdStrobe && wb_adr_i == `FPC_ADR_CLKSEL |=> wb_dat_o[7:6] == 2'h0 && wb_dat_o[3:2] == 2'h0)
    else $error("clock select reserved bits not zero");

  a_oen_reserved: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rdStrobe && wb_adr_i == `FPC_ADR_OEN |=> wb_dat_o[7:6] == 2'h0)
    else $error("enable reserved bits not zero");

  a_phase_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wrStrobe && wb_adr_i == `FPC_ADR_PHL |=>
    phaseCount[7:0] == $past(wb_dat_i[7:0]) && phaseCount[15:8] == $past(phaseHigh_reg))
    else $error("phase low byte write wrong");

  a_phase_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wrStrobe && wb_adr_i == `FPC_ADR_PHH |=> phaseCount[15:8] == $past(wb_dat_i[7:0]))
    else $error("phase high byte write wrong");

  a_reset_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(reset_n) |-> clkSel_reg == 8'h00 && oen_reg == 8'h00 && phaseCount == 16'h0000)
    else $error("registers not cleared by reset");

  a_ack_answers: assert property (@(posedge sys_clk) disable iff (!reset_n)
    busState_reg == fpc_pkg::BUS_IDLE && wb_cyc_i && wb_stb_i |=> wb_ack_o)
    else $error("request not answered in one cycle");

  a_read_upper_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("read data upper lanes not zero");

  a_event_extended: assert property (@(posedge sys_clk) disable iff (!reset_n)
    running && ctrlTick && extend && eventCnt_reg == {1'b0, periodValue} |=> !periodEvent)
    else $error("extended event ended one tick early");

  a_frac_needs_enable: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !ctrl_reg[`FPC_CTRL_FRAC_BIT] [*2] |-> !extend && accum == '0)
    else $error("fraction active while disabled");

  a_off_level_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
    mode == fpc_pkg::MODE_OFF |=> !pwmLevel_reg)
    else $error("pwm level high while off");

endmodule : fpc_top

// [tb/fpc_pin_load.sv]
// far-side model: pll and external clock sources feeding the pwm core
`timescale 1ns/1ps
module fpc_pin_load (
  // clock sources
  output logic pllClk,
  output logic extClkPin
);
  ////////////////////////////////////////////////////////////////////////////////
  // free-running pll clock, 16 ns period
  initial begin
    pllClk = 1'b0;
    forever begin
      #8 pllClk = ~pllClk;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // external clock pin, 24 ns period
  initial begin
    extClkPin = 1'b0;
    forever begin
      #12 extClkPin = ~extClkPin;
    end
  end
endmodule : fpc_pin_load

// [tb/fpc_top_bench.sv]
// self-checking bench for the pwm core
`timescale 1ns/1ps
`include "fpc_map.svh"
module fpc_top_bench;
  logic sysClk, resetN, wbCyc, wbStb, wbWe, wbAck, wbAck2, pllClk, extClkPin, periodEvent;
  logic [7:0] wbAdr;
  logic [31:0] wbDatI, wbDatO, wbDatO2, rd1, rd2;
  logic [3:0] wbSel;
  logic [5:0] portData, pinOut, pa, pb;
  int bad_count, tests_run, c, e;
  int fracSet[3] = '{1, 4, 15};
  ////////////////////////////////////////////////////////////////////////////////
  // design, second unit and far side
  fpc_top DUT (.sys_clk(sysClk), .reset_n(resetN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI), .wb_sel_i(wbSel), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .pllClk(pllClk), .extClkPin(extClkPin), .portData(portData),
    .pinOut(pinOut), .periodEvent(periodEvent));
  fpc_top #(.SECOND_UNIT(1'b1)) DUT2 (.sys_clk(sysClk), .reset_n(resetN), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI), .wb_sel_i(wbSel),
    .wb_dat_o(wbDatO2), .wb_ack_o(wbAck2), .pllClk(pllClk), .extClkPin(extClkPin),
    .portData(portData), .pinOut(), .periodEvent());
  fpc_pin_load load (.pllClk(pllClk), .extClkPin(extClkPin));
  initial begin
    sysClk = 1'b0;
    forever begin
      #2 sysClk = ~sysClk;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // verdict, compare, bus cycle, event timing
  task automatic close_out();
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat);
    int n;
    n = 0;
    @(posedge sysClk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= {24'h00_0000, dat};
    wbSel <= 4'hF;
    do begin
      @(posedge sysClk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    rd1 = wbDatO;
    rd2 = wbDatO2;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      close_out();
    end
  endtask : bus
  task automatic next_ev(inout int cyc);
    int g;
    g = 0;
    do begin
      @(posedge sysClk);
      cyc++;
      g++;
    end while (periodEvent !== 1'b1 && g < 600);
    if (g >= 600) begin
      bad_count++;
      close_out();
    end
  endtask : next_ev
  task automatic span(input int n, output int cyc);
    int d;
    d = 0;
    next_ev(d);
    next_ev(d);
    cyc = 0;
    repeat (n) next_ev(cyc);
  endtask : span
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    bad_count = 0;
    tests_run = 0;
    {wbCyc, wbStb, wbWe, wbAdr, wbDatI, wbSel} = '0;
    portData = 6'h15;
    resetN = 1'b0;
    repeat (5) @(posedge sysClk);
    resetN <= 1'b1;
    for (int a = 0; a < 16; a += 4) begin
      bus(1'b0, a[7:0], 8'h00);
      check(rd1, 32'h0000_0000);
    end
    bus(1'b1, `FPC_ADR_CLKSEL, 8'hFF);
    bus(1'b0, `FPC_ADR_CLKSEL, 8'h00);
    check(rd1, 32'h0000_0033);
    bus(1'b1, `FPC_ADR_OEN, 8'hFF);
    bus(1'b0, `FPC_ADR_OEN, 8'h00);
    check(rd1, 32'h0000_003F);
    check(rd2, 32'h0000_0003);
    bus(1'b1, `FPC_ADR_PHL, 8'hA5);
    bus(1'b1, `FPC_ADR_PHH, 8'h5A);
    bus(1'b0, `FPC_ADR_PHL, 8'h00);
    check(rd1, 32'h0000_00A5);
    bus(1'b0, `FPC_ADR_PHH, 8'h00);
    check(rd1, 32'h0000_005A);
    bus(1'b0, 8'h40, 8'h00);
    check(rd1, 32'h0000_0000);
    bus(1'b1, `FPC_ADR_PRL, 8'h03);
    bus(1'b1, `FPC_ADR_PRH, 8'h00);
    bus(1'b1, `FPC_ADR_CTRL, 8'h01);
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, `FPC_ADR_CLKSEL, 8'(p << 4));
      span(4, c);
      check(c, 16 << p);
    end
    bus(1'b1, `FPC_ADR_CLKSEL, 8'h01);
    span(4, c);
    check(c >= 62 && c <= 66, 1);
    bus(1'b1, `FPC_ADR_CLKSEL, 8'h02);
    span(4, c);
    check(c >= 94 && c <= 98, 1);
    bus(1'b1, `FPC_ADR_CLKSEL, 8'h03);
    repeat (40) @(posedge sysClk);
    e = 0;
    repeat (200) begin
      @(posedge sysClk);
      e += (periodEvent === 1'b1);
    end
    check(e, 0);
    bus(1'b1, `FPC_ADR_CLKSEL, 8'h00);
    bus(1'b1, `FPC_ADR_CTRL, 8'h06);
    foreach (fracSet[i]) begin
      e = fracSet[i];
      bus(1'b1, `FPC_ADR_FRAC, 8'(e));
      span(16, c);
      check(c, 64 + e);
    end
    bus(1'b0, `FPC_ADR_FRAC, 8'h00);
    check(rd1, 32'h0000_000F);
    bus(1'b1, `FPC_ADR_CTRL, 8'h05);
    span(16, c);
    check(c, 64);
    bus(1'b1, `FPC_ADR_CTRL, 8'h02);
    span(1, c);
    repeat (2) @(posedge sysClk);
    pa = pinOut;
    next_ev(c);
    repeat (2) @(posedge sysClk);
    pb = pinOut;
    check(pb[0], !pa[0]);
    check(pb[1], !pb[0]);
    next_ev(c);
    repeat (2) @(posedge sysClk);
    check(pinOut[0], pa[0]);
    bus(1'b1, `FPC_ADR_CTRL, 8'h03);
    span(1, c);
    repeat (2) @(posedge sysClk);
    check(pinOut[1], pinOut[0]);
    portData <= 6'h2A;
    bus(1'b1, `FPC_ADR_OEN, 8'h00);
    repeat (3) @(posedge sysClk);
    check(pinOut, 6'h2A);
    bus(1'b1, `FPC_ADR_OEN, 8'h3C);
    bus(1'b1, `FPC_ADR_CLKSEL, 8'h21);
    @(posedge sysClk);
    resetN <= 1'b0;
    repeat (2) @(posedge sysClk);
    resetN <= 1'b1;
    bus(1'b0, `FPC_ADR_CLKSEL, 8'h00);
    check(rd1, 32'h0000_0000);
    bus(1'b0, `FPC_ADR_OEN, 8'h00);
    check(rd1, 32'h0000_0000);
    bus(1'b0, `FPC_ADR_STAT, 8'h00);
    check(rd1, 32'h0000_0000);
    close_out();
  end
endmodule : fpc_top_bench
